//--- include/hsp_pkg.sv
// Constants, types and helpers shared by the host serial slave port.
// Assumes a SystemVerilog tool; no clocks or resets live here.
package hsp_pkg;

   // ************************************************************
   // Addressing and framing
   // ************************************************************
   localparam logic [5:0] I2C_ADDR_HI = 6'h34;  // Fixed upper bits 110100
   localparam logic [3:0] BYTE_BITS   = 4'h8;   // Bits in one byte
   localparam int         SPI_RW_BIT  = 7;      // Direction bit of address byte
   localparam logic       DIR_READ    = 1'b1;   // Direction code for a read
   localparam logic [7:0] SPI_FILL    = 8'h00;  // Send byte at frame start
   localparam logic [2:0] SPI_LAST    = 3'h7;   // Bit count of a byte's last bit

   // ************************************************************
   // Two-wire states
   // ************************************************************
   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_ADDR = 3'b001,
      I2C_AACK = 3'b010,
      I2C_RX   = 3'b011,
      I2C_RACK = 3'b100,
      I2C_TX   = 3'b101,
      I2C_TACK = 3'b110
   } hsp_i2c_e;

   // Register pointer step, wraps within seven bits
   function automatic logic [6:0] hsp_next(input logic [6:0] p);
      return p + 7'h01;
   endfunction

endpackage

//--- design/hsp_sync3.sv
// Three-stage input synchroniser with an agreement filter.
// Assumes inputs arrive from outside the clk domain.
`timescale 1ns/1ps
module hsp_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // Chain of three; a bit changes once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q      <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q      <= (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));
      end
   end

endmodule

//--- design/hsp_spi_link.sv
// Four-wire shift logic running on the link clock.
// Assumes the select pin frames each transfer and the clock stops between.
`timescale 1ns/1ps
module hsp_spi_link
   import hsp_pkg::*;
(
   input  wire logic       sclk,
   input  wire logic       rst_n,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   input  wire logic [7:0] tx_byte,
   output logic            miso_out,
   output logic            miso_oe,
   output logic      [7:0] byte_out,
   output logic            byte_first,
   output logic            byte_tog
);

   typedef struct packed {
      logic [2:0] cnt;
      logic [6:0] sh;
      logic       seen;
   } hsp_frame_s;

   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       tog;
   } hsp_hold_s;

   hsp_frame_s f_reg;
   hsp_frame_s f_next;
   hsp_hold_s  h_reg;
   hsp_hold_s  h_next;
   logic [7:0] tx_reg;

   // Rising edge shifts in, MSB first; byte handed over by toggle
   always_comb begin
      f_next     = f_reg;
      h_next     = h_reg;
      f_next.sh  = {f_reg.sh[5:0], mosi};             // [R16] [R17]
      f_next.cnt = f_reg.cnt + 3'h1;
      if (f_reg.cnt == SPI_LAST) begin
         f_next.seen  = 1'b1;
         h_next.data  = {f_reg.sh, mosi};
         h_next.first = !f_reg.seen;                   // [R18] [R19]
         h_next.tog   = !h_reg.tog;
      end
   end

   // Frame state is cleared while not selected [R14]
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   // Handed-over byte must outlive the frame for the crossing
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         h_reg <= '0;
      end else begin
         h_reg <= h_next;
      end
   end

   // Falling edge drives out; released whenever not selected
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         tx_reg  <= '0;
         miso_oe <= 1'b0;                               // [R15]
      end else begin
         miso_oe <= 1'b1;
         tx_reg  <= (f_reg.cnt == 3'h0) ? tx_byte : {tx_reg[6:0], 1'b0};  // [R17]
      end
   end

   assign miso_out   = tx_reg[7];
   assign byte_out   = h_reg.data;
   assign byte_first = h_reg.first;
   assign byte_tog   = h_reg.tog;

   msb_first_a: assert property (@(posedge sclk) disable iff (cs_n)  // [R16]
      (f_reg.cnt == SPI_LAST) |=> (h_reg.data == {$past(f_reg.sh), $past(mosi)}))
      else $error("byte not assembled MSB first");

   addr_first_a: assert property (@(posedge sclk) disable iff (cs_n)  // [R19]
      (f_reg.cnt == SPI_LAST) |=> (h_reg.first == !$past(f_reg.seen)))
      else $error("address byte not marked first");

endmodule

//--- design/hsp_port.sv
// Host serial slave port: two-wire target and four-wire slave.
// Assumes a register source answering each read with reg_rvalid.
//
// Function
// R01: Select pin held high picks two-wire mode; driven low picks four-wire.
// R02: Two-wire address is six fixed bits plus the address-select level.
// R03: Device is only a target; clock is driven only to stretch.
// R04: Start and stop seen while clock high; busy from start to stop.
// R05: Two-wire units are eight bits; bytes per transaction unlimited.
// R06: Receiver acknowledges by holding data low across ninth clock high.
// R07: Data left high on the ninth clock means not-acknowledge.
// R08: Device holds clock low until it can send the next byte.
// R09: Master sends seven address bits then direction, 0 write, 1 read.
// R10: Master releases data after address byte and awaits acknowledge.
// R11: Master changes data only while clock low, except start and stop.
// R12: Master ends with stop or issues a repeated start.
// R13: Master keeps two-wire clock to 2.7MHz, four-wire to 6.4MHz; the bench link clock runs at about 66.7MHz.
// R14: Select low frames a four-wire transaction; one target at once.
// R15: Serial output stays released while the select pin is high.
// R16: Four-wire bits travel most significant bit first.
// R17: Four-wire data sampled on rising clock, changed on falling clock.
// R18: Four-wire transaction is one address byte plus data bytes.
// R19: Four-wire address byte: direction bit first, then seven address bits.
// R20: Four-wire port handles single and burst transfers.
// R21: Host keeps each two-wire program to at most 30 bytes.
// R22: Register pointer steps by one after each data byte.
// R23: First two-wire write byte sets pointer; later bytes go onward.
`timescale 1ns/1ps
module hsp_port
   import hsp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       serial_clk,
   output logic            serial_clk_out,
   output logic            serial_clk_oe,
   input  wire logic       serial_in_or_bus_data_in,
   output logic            serial_in_or_bus_data_out,
   output logic            serial_in_or_bus_data_oe,
   input  wire logic       serial_out_or_addr_select_in,
   output logic            serial_out_or_addr_select_out,
   output logic            serial_out_or_addr_select_oe,
   input  wire logic       select_low_pin_n,
   output logic      [6:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   output logic            bus_busy,
   output logic            spi_mode
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      hsp_i2c_e   st;
      logic [3:0] bits;
      logic [7:0] sh;
      logic [7:0] rbuf;
      logic       have;
      logic       waitd;
      logic       nack;
      logic       rd;
      logic       ptrld;
      logic       busy;
      logic [6:0] ptr;
      logic       sda_oe;
      logic       scl_oe;
      logic       scl_q;
      logic       sda_q;
      logic       spi;
      logic       spird;
      logic       tog_q;
      logic [7:0] tx;
      logic       wr;
      logic       rdq;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic       zero;
   } hsp_state_s;

   hsp_state_s s_reg;
   hsp_state_s s_next;
   logic [4:0] sync_q;
   logic       scl_f;
   logic       sda_f;
   logic       ad0_f;
   logic       csn_f;
   logic       tog_f;
   logic [7:0] link_byte;
   logic       link_first;
   logic       link_tog;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic       addr_hit;

   // ************************************************************
   // Pin synchronisers and four-wire link
   // ************************************************************
   hsp_sync3 #(
      .W (5)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({~serial_clk, ~serial_in_or_bus_data_in,
               serial_out_or_addr_select_in, ~select_low_pin_n, link_tog}),
      .q     (sync_q)
   );

   assign {scl_f, sda_f, ad0_f, csn_f, tog_f} = sync_q ^ 5'h1A;  // Idle-high lines leave reset high

   hsp_spi_link u_link (
      .sclk       (serial_clk),
      .rst_n      (rst_n),
      .cs_n       (select_low_pin_n),
      .mosi       (serial_in_or_bus_data_in),
      .tx_byte    (s_reg.tx),
      .miso_out   (serial_out_or_addr_select_out),
      .miso_oe    (serial_out_or_addr_select_oe),
      .byte_out   (link_byte),
      .byte_first (link_first),
      .byte_tog   (link_tog)
   );

   // Bus events on the filtered lines
   assign scl_rise = scl_f && !s_reg.scl_q;
   assign scl_fall = !scl_f && s_reg.scl_q;
   assign start_c  = scl_f && s_reg.scl_q && s_reg.sda_q && !sda_f;  // [R04]
   assign stop_c   = scl_f && s_reg.scl_q && !s_reg.sda_q && sda_f;  // [R04]
   assign addr_hit = (s_reg.sh[7:1] == {I2C_ADDR_HI, ad0_f});        // [R02]

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      s_next       = s_reg;
      s_next.wr    = 1'b0;
      s_next.rdq   = 1'b0;
      s_next.scl_q = scl_f;
      s_next.sda_q = sda_f;
      s_next.spi   = !csn_f;                                 // [R01]
      s_next.tog_q = tog_f;
      // New four-wire frame starts with the fill byte
      if (!csn_f && !s_reg.spi) begin
         s_next.tx = SPI_FILL;
      end
      // Read data goes to the active side
      if (reg_rvalid) begin
         if (s_reg.spi) begin
            s_next.tx = reg_rdata;
         end else begin
            s_next.rbuf = reg_rdata;
            s_next.have = 1'b1;
         end
      end
      if (s_reg.spi) begin
         // Two-wire side parked while selected
         s_next.st     = I2C_IDLE;
         s_next.busy   = 1'b0;
         s_next.sda_oe = 1'b0;
         s_next.scl_oe = 1'b0;
         s_next.waitd  = 1'b0;
         if (tog_f != s_reg.tog_q) begin
            if (link_first) begin
               s_next.spird = link_byte[SPI_RW_BIT];        // [R19]
               s_next.ptr   = link_byte[6:0];
               if (link_byte[SPI_RW_BIT] == DIR_READ) begin
                  s_next.rdq  = 1'b1;
                  s_next.addr = link_byte[6:0];
                  s_next.ptr  = hsp_next(link_byte[6:0]);
               end
            end else begin
               s_next.rdq   = s_reg.spird;                   // [R20]
               s_next.wr    = !s_reg.spird;
               s_next.addr  = s_reg.ptr;
               s_next.wdata = link_byte;
               s_next.ptr   = hsp_next(s_reg.ptr);           // [R22]
            end
         end
      end else if (start_c) begin
         // Start or repeated start: bus busy, expect address
         s_next.st     = I2C_ADDR;                           // [R04]
         s_next.bits   = 4'h0;
         s_next.busy   = 1'b1;
         s_next.sda_oe = 1'b0;
         s_next.scl_oe = 1'b0;
         s_next.waitd  = 1'b0;
      end else if (stop_c) begin
         s_next.st     = I2C_IDLE;                           // [R04]
         s_next.busy   = 1'b0;
         s_next.sda_oe = 1'b0;
         s_next.scl_oe = 1'b0;
         s_next.waitd  = 1'b0;
      end else begin
         case (s_reg.st)
            I2C_ADDR,
            I2C_RX: begin
               if (scl_rise) begin
                  s_next.sh   = {s_reg.sh[6:0], sda_f};
                  s_next.bits = s_reg.bits + 4'h1;           // [R05]
               end else if (scl_fall && s_reg.bits == BYTE_BITS) begin
                  s_next.bits = 4'h0;
                  if (s_reg.st == I2C_ADDR) begin
                     if (addr_hit) begin
                        s_next.st     = I2C_AACK;
                        s_next.sda_oe = 1'b1;                // [R06]
                        s_next.rd     = s_reg.sh[0];
                        s_next.ptrld  = (s_reg.sh[0] != DIR_READ);
                        if (s_reg.sh[0] == DIR_READ) begin
                           s_next.rdq  = 1'b1;
                           s_next.addr = s_reg.ptr;
                           s_next.ptr  = hsp_next(s_reg.ptr);  // [R22]
                           s_next.have = 1'b0;
                        end
                     end else begin
                        s_next.st = I2C_IDLE;                // [R02]
                     end
                  end else begin
                     s_next.st     = I2C_RACK;
                     s_next.sda_oe = 1'b1;                   // [R06]
                     if (s_reg.ptrld) begin
                        s_next.ptr   = s_reg.sh[6:0];        // [R23]
                        s_next.ptrld = 1'b0;
                     end else begin
                        s_next.wr    = 1'b1;
                        s_next.addr  = s_reg.ptr;
                        s_next.wdata = s_reg.sh;
                        s_next.ptr   = hsp_next(s_reg.ptr);  // [R22]
                     end
                  end
               end
            end
            I2C_AACK,
            I2C_RACK: begin
               // Acknowledge held until the ninth clock falls
               if (scl_fall) begin
                  s_next.sda_oe = 1'b0;
                  if (s_reg.rd) begin
                     s_next.st    = I2C_TX;
                     s_next.waitd = 1'b1;
                  end else begin
                     s_next.st = I2C_RX;
                  end
               end
            end
            I2C_TX: begin
               if (s_reg.waitd) begin
                  // Stretch the low clock until read data is here
                  if (s_reg.have) begin
                     s_next.sh     = s_reg.rbuf;
                     s_next.sda_oe = !s_reg.rbuf[7];
                     s_next.have   = 1'b0;
                     s_next.waitd  = 1'b0;
                     s_next.scl_oe = 1'b0;                   // [R08]
                     s_next.bits   = 4'h0;
                  end else begin
                     s_next.scl_oe = 1'b1;                   // [R08] [R03]
                  end
               end else if (scl_fall) begin
                  if (s_reg.bits == BYTE_BITS - 4'h1) begin
                     s_next.st     = I2C_TACK;
                     s_next.sda_oe = 1'b0;
                     s_next.bits   = 4'h0;
                  end else begin
                     s_next.bits   = s_reg.bits + 4'h1;
                     s_next.sh     = {s_reg.sh[6:0], 1'b0};
                     s_next.sda_oe = !s_reg.sh[6];
                  end
               end
            end
            I2C_TACK: begin
               if (scl_rise) begin
                  s_next.nack = sda_f;                       // [R07]
                  if (!sda_f) begin
                     s_next.rdq  = 1'b1;
                     s_next.addr = s_reg.ptr;
                     s_next.ptr  = hsp_next(s_reg.ptr);      // [R22]
                     s_next.have = 1'b0;
                  end
               end else if (scl_fall) begin
                  if (s_reg.nack) begin
                     s_next.st = I2C_IDLE;                   // [R07]
                  end else begin
                     s_next.st    = I2C_TX;
                     s_next.waitd = 1'b1;
                  end
               end
            end
            default: begin
               s_next.st = I2C_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // State register and outputs
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign serial_clk_out            = s_reg.zero;
   assign serial_clk_oe             = s_reg.scl_oe;
   assign serial_in_or_bus_data_out = s_reg.zero;
   assign serial_in_or_bus_data_oe  = s_reg.sda_oe;
   assign reg_addr                  = s_reg.addr;
   assign reg_wdata                 = s_reg.wdata;
   assign reg_wr                    = s_reg.wr;
   assign reg_rd                    = s_reg.rdq;
   assign bus_busy                  = s_reg.busy;
   assign spi_mode                  = s_reg.spi;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_addr_end;
      !s_reg.spi && (s_reg.st == I2C_ADDR) && scl_fall && (s_reg.bits == BYTE_BITS);
   endsequence

   sequence s_wr_ptr_byte;
      !s_reg.spi && (s_reg.st == I2C_RX) && s_reg.ptrld && scl_fall
         && (s_reg.bits == BYTE_BITS);
   endsequence

   addr_hit_a: assert property (s_addr_end ##0 addr_hit |=>  // [R02]
      (s_reg.st == I2C_AACK) && s_reg.sda_oe)
      else $error("matching address not acknowledged");

   addr_miss_a: assert property (s_addr_end ##0 !addr_hit |=>  // [R02]
      (s_reg.st == I2C_IDLE) && !s_reg.sda_oe)
      else $error("foreign address acknowledged");

   clock_low_a: assert property ($rose(s_reg.scl_oe) |-> !scl_f)  // [R03]
      else $error("clock pulled while high");

   start_seen_a: assert property (!s_reg.spi && start_c |=>  // [R04]
      (s_reg.st == I2C_ADDR) && s_reg.busy && (s_reg.bits == 4'h0))
      else $error("start not taken");

   stop_seen_a: assert property (!s_reg.spi && stop_c |=> !s_reg.busy)  // [R04]
      else $error("stop did not free the bus");

   byte_width_a: assert property (s_reg.bits <= BYTE_BITS)  // [R05]
      else $error("bit count beyond a byte");

   ack_hold_a: assert property (!s_reg.spi && scl_f && !start_c && !stop_c  // [R06]
      && (s_reg.st == I2C_AACK || s_reg.st == I2C_RACK) |-> s_reg.sda_oe)
      else $error("acknowledge released during clock high");

   nack_end_a: assert property (!s_reg.spi && (s_reg.st == I2C_TACK)  // [R07]
      && s_reg.nack && scl_fall |=> (s_reg.st == I2C_IDLE) && !s_reg.sda_oe)
      else $error("sending continued after not-acknowledge");

   stretch_why_a: assert property (s_reg.scl_oe |->  // [R08]
      (s_reg.st == I2C_TX) && s_reg.waitd)
      else $error("clock held without waiting for data");

   stretch_end_a: assert property (s_reg.scl_oe && s_reg.have && !start_c  // [R08]
      && !stop_c && !s_reg.spi |=> !s_reg.scl_oe && (s_reg.sh == $past(s_reg.rbuf)))
      else $error("clock not released with data");

   mode_pick_a: assert property (csn_f |=> !s_reg.spi)  // [R01]
      else $error("four-wire mode with select high");

   sdo_idle_a: assert property (select_low_pin_n |->  // [R15]
      !serial_out_or_addr_select_oe)
      else $error("serial output driven while deselected");

   ptr_step_a: assert property ((s_reg.wr || s_reg.rdq) |->  // [R22]
      (s_reg.ptr == hsp_next(s_reg.addr)))
      else $error("pointer did not step after access");

   ptr_load_a: assert property (s_wr_ptr_byte |=>  // [R23]
      !s_reg.wr && (s_reg.ptr == $past(s_reg.sh[6:0])))
      else $error("first write byte not taken as pointer");

endmodule

//--- tb/hsp_host_model.sv
// Host master model: two-wire master and four-wire master.
// Assumes the bench resolves the open-drain lines and the strap level.
`timescale 1ns/1ps
module hsp_host_model (
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic so,
   output logic      m_clk,
   output logic      m_dat,
   output logic      cs_n,
   output logic      hung
);
   // ****************************
   // Clocks and lines
   // ****************************
   logic lclk = 1'b0;
   logic run  = 1'b0;
   logic ic   = 1'b1;
   // Link clock with a phase unrelated to clk
   initial begin
      m_dat = 1'b1;
      cs_n = 1'b1;
      hung = 1'b0;
      #3.1;
      forever #7.5 lclk = ~lclk;
   end
   // Link clock stands still outside bytes; select high means two-wire
   assign m_clk = cs_n ? ic : (run & lclk);
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One clock pulse, waiting out any stretch under a bound
   task automatic pulse(output logic v);
      int k;
      wt(10);
      ic <= 1'b1;
      for (k = 0; k < 400 && scl !== 1'b1; k++)
         wt(1);
      hung <= (k == 400);
      wt(10);
      #1 v = sda;
      wt(10);
      ic <= 1'b0;
      wt(10);
   endtask
   // Start or repeated start when s is 1, stop when s is 0
   task automatic cond(input logic s);
      m_dat <= s;
      wt(10);
      ic <= 1'b1;
      wt(20);
      m_dat <= ~s;
      wt(20);
      if (s)
         ic <= 1'b0;
      wt(10);
   endtask
   // Byte MSB first, data changed only while clock low, then ninth clock
   task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] got,
                       output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         m_dat <= b[i];
         pulse(got[i]);
      end
      m_dat <= ~mack;  // Released for the answer, or pulled low to acknowledge
      pulse(a);
      ack = ~a;
   endtask
   // Select frames a transaction, one target at a time
   task automatic sel(input logic v);
      cs_n <= v;
      wt(10);
   endtask
   // Link byte: change on falling edge, sample on rising, MSB first
   task automatic sbyte(input logic [7:0] b, output logic [7:0] got);
      wt(20);
      @(negedge lclk);
      run = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         m_dat = b[i];
         @(posedge lclk);
         got[i] = so;
         @(negedge lclk);
      end
      run = 1'b0;
   endtask
endmodule

//--- tb/tb_top.sv
// Bench for the host serial slave port: two-wire and four-wire traffic.
// Assumes hsp_pkg is compiled first and the host model drives the pins.
`timescale 1ns/1ps
module tb_top
   import hsp_pkg::*;
();
   logic       clk = 1'b0, rst_n, strap, reg_rvalid;
   logic [7:0] reg_rdata, reg_wdata;
   logic [6:0] reg_addr;
   logic       serial_clk_out, serial_clk_oe, serial_in_or_bus_data_out, reg_wr, reg_rd;
   logic       serial_in_or_bus_data_oe, serial_out_or_addr_select_out, bus_busy, spi_mode;
   logic       serial_out_or_addr_select_oe, m_clk, m_dat, select_low_pin_n, hung;
   wire        serial_clk, serial_in_or_bus_data_in, serial_out_or_addr_select_in;
   logic [31:0] rnd = 32'h85E2;
   logic [15:0] wq[$];
   int          num_errors = 0, check_count = 0, rd_wait = 0;
   // ****************************
   // Pins, design and host
   // ****************************
   always #12.5 clk = ~clk;
   // Open-drain lines pulled high; strap shows when the output is released
   assign serial_clk = m_clk & ~serial_clk_oe;
   assign serial_in_or_bus_data_in = m_dat & ~serial_in_or_bus_data_oe;
   assign serial_out_or_addr_select_in = serial_out_or_addr_select_oe ?
                                         serial_out_or_addr_select_out : strap;
   hsp_port hsp_port_i (
      .clk, .rst_n, .serial_clk, .serial_clk_out, .serial_clk_oe,
      .serial_in_or_bus_data_in, .serial_in_or_bus_data_out, .serial_in_or_bus_data_oe,
      .serial_out_or_addr_select_in, .serial_out_or_addr_select_out,
      .serial_out_or_addr_select_oe, .select_low_pin_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .reg_rvalid, .bus_busy, .spi_mode
   );
   hsp_host_model hsp_host_model_i (
      .clk, .scl(serial_clk), .sda(serial_in_or_bus_data_in),
      .so(serial_out_or_addr_select_in), .m_clk, .m_dat, .cs_n(select_low_pin_n), .hung
   );
   // ****************************
   // Checking helpers
   // ****************************
   function automatic logic [7:0] rv(input logic [6:0] a);
      return {1'b0, a} ^ 8'hA5;
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Register source: quick in four-wire mode, slow in two-wire mode to force a stretch
   always @(posedge clk) begin
      rd_wait <= (reg_rd === 1'b1) ? (spi_mode ? 1 : 60) : rd_wait - (rd_wait > 0);
      reg_rvalid <= (rd_wait == 1);
      reg_rdata <= rv(reg_addr);
      if (reg_wr === 1'b1)
         check("write", {1'b0, reg_addr, reg_wdata}, wq.size() ? wq.pop_front() : 16'hFFFF);
      if (hung === 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
   end
   // ****************************
   // Main sequence
   // ****************************
   initial begin
      logic [7:0] got;
      logic       ack;
      logic [6:0] p;
      logic [7:0] d;
      rst_n <= 1'b0;
      rnd = lfsr(rnd);
      strap <= rnd[16];
      p = rnd[6:0];
      d = rnd[15:8];
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      check("idle", {serial_clk_oe, serial_in_or_bus_data_oe, bus_busy, spi_mode}, 0);
      // Foreign address is left unanswered
      hsp_host_model_i.cond(1'b1);
      check("busy", bus_busy, 1);
      hsp_host_model_i.xfer({I2C_ADDR_HI, ~strap, 1'b0}, 1'b0, got, ack);
      check("foreign ack", ack, 0);
      hsp_host_model_i.cond(1'b0);
      check("free", bus_busy, 0);
      // Pointer and data write, repeated start, two-byte read; a short program
      hsp_host_model_i.cond(1'b1);
      hsp_host_model_i.xfer({I2C_ADDR_HI, strap, 1'b0}, 1'b0, got, ack);
      check("own ack", ack, 1);
      hsp_host_model_i.xfer({1'b0, p}, 1'b0, got, ack);
      wq.push_back({1'b0, p, d});
      hsp_host_model_i.xfer(d, 1'b0, got, ack);
      check("data ack", ack, 1);
      hsp_host_model_i.cond(1'b1);
      check("busy sr", bus_busy, 1);
      hsp_host_model_i.xfer({I2C_ADDR_HI, strap, DIR_READ}, 1'b0, got, ack);
      for (int i = 1; i <= 2; i++) begin
         hsp_host_model_i.xfer(8'hFF, i == 1, got, ack);
         check("read", got, rv(p + i));
      end
      hsp_host_model_i.cond(1'b0);
      // Four-wire burst write, then burst read
      rnd = lfsr(rnd);
      p = rnd[6:0];
      d = rnd[15:8];
      hsp_host_model_i.sel(1'b0);
      check("mode", spi_mode, 1);
      wq.push_back({1'b0, p, d});
      wq.push_back({1'b0, p + 7'h01, ~d});
      hsp_host_model_i.sbyte({1'b0, p}, got);
      hsp_host_model_i.sbyte(d, got);
      hsp_host_model_i.sbyte(~d, got);
      hsp_host_model_i.sel(1'b1);
      check("released", serial_out_or_addr_select_oe, 0);
      hsp_host_model_i.sel(1'b0);
      hsp_host_model_i.sbyte({DIR_READ, p}, got);
      for (int i = 0; i < 3; i++) begin
         hsp_host_model_i.sbyte(rnd[23:16], got);
         check("spi read", got, i == 0 ? SPI_FILL : rv(p + i - 1));
      end
      hsp_host_model_i.sel(1'b1);
      repeat (20) @(posedge clk);
      check("notes left", wq.size(), 0);
      tally_and_finish();
   end
endmodule
